// File: core/mil_irq_logic.sv
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
module mil_irq_logic #(
  parameter int STACK_DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic wb_we_i, // Write strobe
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic [2:0] core_event_i, // Core source pulses
  input wire logic [7:0] periph1_event_i, // Flags1 source pulses
  input wire logic [7:0] periph2_event_i, // Flags2 source pulses
  input wire logic [14:0] cpu_pc_i, // Next PC from core
  input wire logic [7:0] cpu_ctx_i, // Critical registers
  input wire logic return_from_interrupt_i, // Return instruction
  output logic flush_o, // Flush prefetched word
  output logic pc_load_o, // Load PC strobe
  output logic [14:0] pc_value_o, // PC to load
  output logic [7:0] ctx_restore_o, // Restored registers
  output logic irq_o // Event interrupt level
);
  logic [7:0] core_ctrl_reg;
  logic [7:0] flags1_reg;
  logic [7:0] flags2_reg;
  logic [7:0] enable1_reg;
  logic [7:0] enable2_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic bus_req;
  logic wr_core, wr_f1, wr_f2, wr_e1, wr_e2, wr_mask;
  logic rd_status;
  logic request;
  logic take;
  logic [31:0] rd_next;
  mil_ctx_if ctx ();

  function automatic logic [7:0] merge(input logic [7:0] old,
      input logic [31:0] d, input logic lane);
    merge = lane ? d[7:0] : old;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_core = bus_req && wb_we_i &&
                   hit(wb_adr_i, {4'h0, mil_pkg::OFF_CORE_CTRL});
  assign wr_f1 = bus_req && wb_we_i &&
                 hit(wb_adr_i, {4'h0, mil_pkg::OFF_FLAGS1});
  assign wr_f2 = bus_req && wb_we_i &&
                 hit(wb_adr_i, {4'h0, mil_pkg::OFF_FLAGS2});
  assign wr_e1 = bus_req && wb_we_i &&
                 hit(wb_adr_i, {4'h0, mil_pkg::OFF_ENABLE1});
  assign wr_e2 = bus_req && wb_we_i &&
                 hit(wb_adr_i, mil_pkg::OFF_ENABLE2);
  assign wr_mask = bus_req && wb_we_i &&
                   hit(wb_adr_i, mil_pkg::OFF_IRQ_MASK);
  assign rd_status = bus_req && !wb_we_i &&
                     hit(wb_adr_i, mil_pkg::OFF_IRQ_STATUS);

  // group enable only for peripheral banks
  assign request = core_ctrl_reg[mil_pkg::BIT_GLOBAL] &&
    ((|(core_ctrl_reg[5:3] & core_ctrl_reg[2:0])) ||
     (core_ctrl_reg[mil_pkg::BIT_GROUP] &&
      (|(flags1_reg & enable1_reg) || |(flags2_reg & enable2_reg))));
  // flags persist, so request reasserts when global returns
  assign take = ce && request && !return_from_interrupt_i;

  assign ctx.save = take;
  assign ctx.restore = ce && return_from_interrupt_i;
  assign ctx.pc_in = cpu_pc_i;
  assign ctx.ctx_in = cpu_ctx_i;

  mil_context_store #(
    .DEPTH(STACK_DEPTH)
  ) u_store (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .ctx(ctx)
  );

  // enables cleared, global cleared on accept, set on return
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_ctrl_reg <= mil_pkg::CORE_RESET;
    end else if (ce) begin
      logic [7:0] v;
      v = wr_core ? merge(core_ctrl_reg, wb_dat_i, wb_sel_i[0])
                  : core_ctrl_reg;
      // core flags set regardless, set wins over clear
      v[2:0] = v[2:0] | core_event_i;
      if (take) begin
        v[mil_pkg::BIT_GLOBAL] = 1'b0;
      end else if (return_from_interrupt_i) begin
        v[mil_pkg::BIT_GLOBAL] = 1'b1;
      end
      core_ctrl_reg <= v;
    end
  end

  // bit order follows event port order 7..0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags1_reg <= mil_pkg::FLAGS_RESET;
      flags2_reg <= mil_pkg::FLAGS_RESET;
    end else if (ce) begin
      flags1_reg <= (wr_f1 ? merge(flags1_reg, wb_dat_i, wb_sel_i[0])
                           : flags1_reg) | periph1_event_i;
      flags2_reg <= (wr_f2 ? merge(flags2_reg, wb_dat_i, wb_sel_i[0])
                           : flags2_reg) | periph2_event_i;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable1_reg <= mil_pkg::ENABLE_RESET;
      enable2_reg <= mil_pkg::ENABLE_RESET;
      irq_mask_reg <= 2'h0;
    end else if (ce) begin
      if (wr_e1) enable1_reg <= merge(enable1_reg, wb_dat_i, wb_sel_i[0]);
      if (wr_e2) enable2_reg <= merge(enable2_reg, wb_dat_i, wb_sel_i[0]);
      if (wr_mask && wb_sel_i[0]) irq_mask_reg <= wb_dat_i[1:0];
    end
  end

  // Sticky events, read clears, new event wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_status_reg <= 2'h0;
    end else if (ce) begin
      irq_status_reg <= (rd_status ? 2'h0 : irq_status_reg) |
        {return_from_interrupt_i, take};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_o <= 1'b0;
    end else if (ce) begin
      irq_o <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // flush, vector load; return loads popped PC
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flush_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_value_o <= 15'h0000;
      ctx_restore_o <= 8'h00;
    end else if (ce) begin
      flush_o <= take;
      pc_load_o <= take || return_from_interrupt_i;
      if (take) begin
        pc_value_o <= mil_pkg::IRQ_VECTOR;
      end else if (return_from_interrupt_i) begin
        pc_value_o <= ctx.pc_out;
        ctx_restore_o <= ctx.ctx_out;
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (wb_adr_i)
      {4'h0, mil_pkg::OFF_CORE_CTRL}: rd_next[7:0] = core_ctrl_reg;
      {4'h0, mil_pkg::OFF_FLAGS1}: rd_next[7:0] = flags1_reg;
      {4'h0, mil_pkg::OFF_FLAGS2}: rd_next[7:0] = flags2_reg;
      {4'h0, mil_pkg::OFF_ENABLE1}: rd_next[7:0] = enable1_reg;
      mil_pkg::OFF_ENABLE2: rd_next[7:0] = enable2_reg;
      mil_pkg::OFF_IRQ_STATUS: rd_next[1:0] = irq_status_reg;
      mil_pkg::OFF_IRQ_MASK: rd_next[1:0] = irq_mask_reg;
      mil_pkg::OFF_CPU_STATE: rd_next[0] = request;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Single-wait ack; unmapped reads give zero, writes ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) wb_dat_o <= rd_next;
    end
  end

  a_take_clears_global: assert property (@(posedge clk) disable iff (sys_rst)
    take |=> !core_ctrl_reg[mil_pkg::BIT_GLOBAL])
    else $error("global enable not cleared on accept");
  a_take_vector: assert property (@(posedge clk) disable iff (sys_rst)
    take |=> pc_load_o && flush_o && pc_value_o == mil_pkg::IRQ_VECTOR)
    else $error("vector not loaded");
  a_ret_sets_global: assert property (@(posedge clk) disable iff (sys_rst)
    ce && return_from_interrupt_i |=> core_ctrl_reg[mil_pkg::BIT_GLOBAL])
    else $error("return did not set global");
  a_event_recorded: assert property (@(posedge clk) disable iff (sys_rst)
    ce && periph1_event_i[0] |=> flags1_reg[0])
    else $error("flag event lost");
  a_no_take_global: assert property (@(posedge clk) disable iff (sys_rst)
    !core_ctrl_reg[mil_pkg::BIT_GLOBAL] |-> !take)
    else $error("taken with global clear");
  a_group_gate: assert property (@(posedge clk) disable iff (sys_rst)
    !core_ctrl_reg[mil_pkg::BIT_GROUP] &&
    !(|(core_ctrl_reg[5:3] & core_ctrl_reg[2:0])) |-> !request)
    else $error("request without group enable");
  a_reset_clear: assert property (@(posedge clk)
    $fell(sys_rst) |-> core_ctrl_reg == 8'h00 && enable1_reg == 8'h00)
    else $error("enables not cleared by reset");
  // pending flag serviced after global set
  a_pending_serviced: assert property (@(posedge clk) disable iff (sys_rst)
    ce && !return_from_interrupt_i && request |-> take)
    else $error("pending request not serviced");
  a_flag_write: assert property (@(posedge clk) disable iff (sys_rst)
    ce && wr_f1 && wb_sel_i[0] && periph1_event_i == 8'h00
    |=> flags1_reg == $past(wb_dat_i[7:0]))
    else $error("flag write lost");
endmodule

// File: core/mil_pkg.sv
package mil_pkg;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CORE_CTRL = 4'h0;
  localparam logic [3:0] OFF_FLAGS1 = 4'h4;
  localparam logic [3:0] OFF_FLAGS2 = 4'h8;
  localparam logic [3:0] OFF_ENABLE1 = 4'hC;
  // Byte addresses that need more than 4 bits are 8 bits wide; every decode compares all 8 address bits
  localparam logic [7:0] OFF_ENABLE2 = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_CPU_STATE = 8'h1C;
  // Core control bits
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_GROUP = 6;
  localparam logic [7:0] CORE_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [14:0] IRQ_VECTOR = 15'h0004;
  localparam int PC_W = 15;
  // Status event bits
  localparam int EV_TAKEN = 0;
  localparam int EV_RETURN = 1;
endpackage

// File: core/mil_ctx_if.sv
`timescale 1ns/1ps
interface mil_ctx_if;
  logic save;
  logic restore;
  logic [14:0] pc_in;
  logic [7:0] ctx_in;
  logic [14:0] pc_out;
  logic [7:0] ctx_out;
  modport ctrl (output save, restore, pc_in, ctx_in,
                input pc_out, ctx_out);
  modport store (input save, restore, pc_in, ctx_in,
                 output pc_out, ctx_out);
endinterface

// File: core/mil_context_store.sv
`timescale 1ns/1ps
module mil_context_store #(
  parameter int DEPTH = 8
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic ce, // Clock enable
  mil_ctx_if.store ctx // Save and restore port
);
  logic [14:0] stack_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] sp_reg;
  logic [7:0] shadow_reg;
  logic [$clog2(DEPTH)-1:0] top;

  assign top = sp_reg - 1'b1;
  assign ctx.pc_out = stack_mem[top];
  assign ctx.ctx_out = shadow_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sp_reg <= '0;
    end else if (ce) begin
      if (ctx.save) begin
        sp_reg <= sp_reg + 1'b1;
      end else if (ctx.restore) begin
        sp_reg <= top;
      end
    end
  end

  // Stack array has no reset, only pointer matters
  always_ff @(posedge clk) begin
    if (ce && ctx.save) begin
      stack_mem[sp_reg] <= ctx.pc_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_reg <= 8'h00;
    end else if (ce && ctx.save) begin
      shadow_reg <= ctx.ctx_in;
    end
  end
endmodule

// File: dv/mil_cpu_model.sv
`timescale 1ns/1ps
module mil_cpu_model (
  input wire logic clk, // System clock
  output logic [2:0] core_ev, // Core source pulses
  output logic [7:0] p1_ev, // Flags1 source pulses
  output logic [7:0] p2_ev, // Flags2 source pulses
  output logic [14:0] pc, // Return address
  output logic [7:0] ctx, // Critical registers
  output logic ret // Return instruction
);
  initial begin
    core_ev = 3'h0;
    p1_ev = 8'h00;
    p2_ev = 8'h00;
    pc = 15'h0000;
    ctx = 8'h00;
    ret = 1'b0;
  end
  // Strobes last one cycle, as a peripheral would raise them
  task fire(input logic [7:0] a, input logic [7:0] b);
    @(posedge clk);
    p1_ev <= a;
    p2_ev <= b;
    @(posedge clk);
    p1_ev <= 8'h00;
    p2_ev <= 8'h00;
  endtask
  task fire_core(input logic [2:0] a);
    @(posedge clk);
    core_ev <= a;
    @(posedge clk);
    core_ev <= 3'h0;
  endtask
  task load(input logic [14:0] p, input logic [7:0] c);
    @(posedge clk);
    pc <= p;
    ctx <= c;
  endtask
  task do_ret;
    @(posedge clk);
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
  endtask
endmodule

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rdat;
  logic ack, ret, flush, pcld, irq;
  logic [2:0] cev;
  logic [7:0] p1, p2, ctx, ctx_r, ret_ctx;
  logic [14:0] pc, pcv, acc_pc, ret_pc;
  logic [15:0] q;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_acc = 0;
  int n_ret = 0;
  always #20 clk = ~clk;
  mil_cpu_model cpu_u (.clk(clk), .core_ev(cev), .p1_ev(p1), .p2_ev(p2),
    .pc(pc), .ctx(ctx), .ret(ret));
  mil_irq_logic dut_u (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .core_event_i(cev), .periph1_event_i(p1), .periph2_event_i(p2),
    .cpu_pc_i(pc), .cpu_ctx_i(ctx), .return_from_interrupt_i(ret),
    .flush_o(flush), .pc_load_o(pcld), .pc_value_o(pcv),
    .ctx_restore_o(ctx_r), .irq_o(irq));
  // Flush marks an accept; a load without flush is a return
  always @(posedge clk) begin
    if (pcld === 1'b1 && flush === 1'b1) begin
      n_acc++;
      acc_pc = pcv;
    end
    if (pcld === 1'b1 && flush !== 1'b1) begin
      n_ret++;
      ret_pc = pcv;
      ret_ctx = ctx_r;
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    sel <= 4'h1;
    cyc <= 1'b1;
    stb <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(q, {8'h00, e});
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask
  // Let the monitor's updates at the edge land first
  task cwait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(40 * 5000);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h24, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      cpu_u.fire(8'h01 << i, 8'h0F);
      rd(8'h04, 8'h01 << i);
      wr(8'h04, 8'h00);
    end
    rd(8'h08, 8'h0F);
    wr(8'h04, 8'h5A);
    rd(8'h04, 8'h5A);
    wr(8'h04, 8'h00);
    $display("test flags done");
    wr(8'h0C, 8'h02);
    wr(8'h18, 8'h03);
    cpu_u.load(15'h0123, 8'h5A);
    cpu_u.fire(8'h02, 8'h00);
    wr(8'h00, 8'h80);
    cwait(4);
    chk(n_acc, 16'h0000);
    wr(8'h00, 8'hC0);
    cwait(4);
    chk(n_acc, 16'h0001);
    chk({1'b0, acc_pc}, 16'h0004);
    chk(irq, 16'h0001);
    rd(8'h00, 8'h40);
    rd(8'h04, 8'h02);
    rd(8'h14, 8'h01);
    rd(8'h14, 8'h00);
    cwait(2);
    chk(irq, 16'h0000);
    $display("test accept done");
    cpu_u.do_ret;
    cwait(4);
    chk(n_ret, 16'h0001);
    chk({1'b0, ret_pc}, 16'h0123);
    chk(ret_ctx, 16'h005A);
    chk(n_acc, 16'h0002);
    wr(8'h04, 8'h00);
    cpu_u.do_ret;
    cwait(4);
    chk(n_acc, 16'h0002);
    rd(8'h00, 8'hC0);
    $display("test return done");
    wr(8'h00, 8'h40);
    cpu_u.fire(8'h02, 8'h00);
    cwait(4);
    chk(n_acc, 16'h0002);
    rd(8'h04, 8'h02);
    wr(8'h00, 8'hC0);
    cwait(4);
    chk(n_acc, 16'h0003);
    $display("test masked done");
    wr(8'h04, 8'h00);
    cpu_u.fire_core(3'h1);
    rd(8'h00, 8'h41);
    wr(8'h00, 8'h89);
    cwait(4);
    chk(n_acc, 16'h0004);
    rd(8'h00, 8'h09);
    rd(8'h1C, 8'h00);
    $display("test core source done");
    give_verdict;
  end
endmodule
